// File: hw/csp_pkg.sv
// Shared constants, register map and state type of the CC/SBU protection switch controller.
package csp_pkg;

  // Serial control port address (7 bits, R/W bit appended by the host).
  localparam logic [6:0] I2C_ADDR = 7'h28;

  // Register offsets.
  localparam logic [7:0] REG_CTRL   = 8'h02;
  localparam logic [7:0] REG_SWCTL  = 8'h03;
  localparam logic [7:0] REG_MASK   = 8'h04;
  localparam logic [7:0] REG_INT    = 8'h05;
  localparam logic [7:0] REG_STATUS = 8'h07;
  localparam logic [7:0] REG_DEVRST = 8'h0B;

  // Field positions.
  localparam int CTRL_MAN_BIT   = 0;
  localparam int SW_CC_BIT      = 0;
  localparam int SW_SBU_BIT     = 1;
  localparam int SW_FM_SBU2_BIT = 2;
  localparam int DEVRST_BIT     = 0;
  localparam int INT_OVP_CC     = 0;
  localparam int INT_OVP_SBU    = 1;
  localparam int INT_REC_CC     = 2;
  localparam int INT_REC_SBU    = 3;

  // Reset values.
  localparam logic       CTRL_RST  = 1'h0;
  localparam logic [2:0] SWCTL_RST = 3'h3;
  localparam logic [3:0] MASK_RST  = 4'h0;
  localparam logic [3:0] INT_RST   = 4'h0;

  // Timing.
  localparam int CLK_PERIOD_NS  = 20;
  localparam int SCL_MAX_KHZ    = 400;
  localparam int SPIKE_NS       = 50;
  localparam int FILT_CYCLES    = (SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
  localparam int OVP_RESP_NS    = 500;
  localparam int OVP_RESP_CYC   = OVP_RESP_NS / CLK_PERIOD_NS;
  localparam logic [3:0] RST_HOLD_CYC = 4'h8;

  // Serial port states.
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RX,
    ST_ACK,
    ST_TX,
    ST_HACK,
    ST_WAIT
  } csp_i2c_state_t;

endpackage : csp_pkg

// File: hw/csp_pin_filter.sv
// Two-stage synchroniser and spike filter for the asynchronous input pins.
`timescale 1ns/100ps
module csp_pin_filter #(
  parameter int WIDTH  = 6,
  parameter int STABLE = 4
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  // Pins and filtered levels
  input  wire logic [WIDTH-1:0] pin_i,
  output logic      [WIDTH-1:0] filt_o
);

  localparam int CW = $clog2(STABLE + 1);

  if (STABLE < 2 || STABLE > 15) begin : g_bad_stable
    $error("STABLE must lie between 2 and 15");
  end

  logic [WIDTH-1:0] sync1;
  logic [WIDTH-1:0] sync2;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= pin_i;
      sync2 <= sync1;
    end
  end

  // A level must differ for STABLE samples in a row, so a short spike never moves the output.
  // Each bit keeps its level in a flop of its own, so no two processes write the output vector.
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    logic [CW-1:0] cnt;
    logic          lvl;
    always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
        cnt <= '0;
        lvl <= 1'b0;
      end else if (sync2[i] == lvl) begin
        cnt <= '0;
      end else if (cnt == CW'(STABLE - 1)) begin
        cnt <= '0;
        lvl <= sync2[i];
      end else begin
        cnt <= cnt + CW'(1);
      end
    end
    assign filt_o[i] = lvl;
  end

endmodule : csp_pin_filter

// File: hw/csp_protect_ctrl.sv
// Switch, dead-battery, over-voltage, interrupt and serial register control of the protection switch.
//
// Function
// - Close CC and SBU after valid supply
// - Sink pulldown on both CC without supply
// - Undervoltage: open switches, reapply pulldown
// - Device reset bit restores defaults, reopens briefly
// - Supply return removes pulldown, closes CC
// - Over-voltage opens affected path promptly
// - CC fault opens CC only; SBU fault SBU
// - Over-voltage updates interrupt register, asserts output
// - Fault removal recloses path, raises recovery interrupt
// - Factory pin to SBU1, manual SBU2
// - Pulled-down factory pin uses normal SBU switches
// - Manual setting overrides, over-voltage still opens
// - Any interrupt register change asserts output
// - Output stays low until interrupt register read
// - Interrupt output works straight after reset
// - Masks reset clear; masked bits never set
// - Serial clock up to 400 kHz
// - Reject serial input spikes up to 50 ns
// - Serial slave at address 0101000
`timescale 1ns/100ps
module csp_protect_ctrl (
  // Clock and reset
  input  wire logic CLOCK_I,
  input  wire logic RST_N_I,
  // Serial control port
  input  wire logic SCL_I,
  input  wire logic SDA_I,
  output logic      SDA_O,
  output logic      SDA_OE_O,
  // Open-drain interrupt
  output logic      INTERRUPT_OUT_N_O,
  output logic      INTERRUPT_OUT_N_OE_O,
  // Analog monitors
  input  wire logic VDD_VALID_I,
  input  wire logic OVP_CC_I,
  input  wire logic OVP_SBU_I,
  input  wire logic FACTORY_TEST_PIN_PD_I,
  // Switch drives
  output logic      CC_SW_CLOSE_O,
  output logic      SBU_SW_CLOSE_O,
  output logic      DEAD_BATT_RD_O,
  output logic      FM_TO_SBU1_O,
  output logic      FM_TO_SBU2_O
);
  import csp_pkg::*;

  if (FILT_CYCLES + 4 > OVP_RESP_CYC) begin : g_bad_timing
    $error("Input filter too slow for the over-voltage response time");
  end

  logic [5:0] filt;
  wire        scl     = filt[0];
  wire        sda     = filt[1];
  wire        pwr_ok  = filt[2];
  wire        ovp_cc  = filt[3];
  wire        ovp_sbu = filt[4];
  wire        fm_pin  = filt[5];

  // The filter settles well within one SCL phase at the top bus rate.
  csp_pin_filter #(
    .WIDTH  (6),
    .STABLE (FILT_CYCLES)
  ) u_filt (
    .clk_i   (CLOCK_I),
    .rst_n_i (RST_N_I),
    .pin_i   ({FACTORY_TEST_PIN_PD_I, OVP_SBU_I, OVP_CC_I, VDD_VALID_I, SDA_I, SCL_I}),
    .filt_o  (filt)
  );

  logic           scl_d;
  logic           sda_d;
  logic           ovp_cc_d;
  logic           ovp_sbu_d;
  csp_i2c_state_t state;
  logic [3:0]     bit_cnt;
  logic [7:0]     shreg;
  logic [7:0]     ptr;
  logic           first;
  logic           ptr_ph;
  logic           is_read;
  logic           hnack;
  logic           sda_oe;
  logic           wr_en;
  logic [7:0]     wr_addr;
  logic [7:0]     wr_data;
  logic           int_clr;
  logic [3:0]     int_rd;
  logic           soft_rst;
  logic           man_active;
  logic [2:0]     man_cfg;
  logic [2:0]     swctl;
  logic [3:0]     mask;
  logic [3:0]     int_reg;
  logic           int_low;
  logic [3:0]     hold;
  logic           fm_pd;

  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      scl_d     <= 1'b0;
      sda_d     <= 1'b0;
      ovp_cc_d  <= 1'b0;
      ovp_sbu_d <= 1'b0;
    end else begin
      scl_d     <= scl;
      sda_d     <= sda;
      ovp_cc_d  <= ovp_cc;
      ovp_sbu_d <= ovp_sbu;
    end
  end

  wire scl_rise   = scl & ~scl_d;
  wire scl_fall   = ~scl & scl_d;
  wire start_c    = scl & scl_d & sda_d & ~sda;
  wire stop_c     = scl & scl_d & ~sda_d & sda;
  wire addr_match = (shreg[7:1] == I2C_ADDR);
  wire load_now   = scl_fall & (((state == ST_ACK) & is_read) | ((state == ST_HACK) & ~hnack));

  wire [7:0] rd_data =
    (ptr == REG_CTRL)   ? {7'h00, man_active} :
    (ptr == REG_SWCTL)  ? {5'h00, swctl} :
    (ptr == REG_MASK)   ? {4'h0, mask} :
    (ptr == REG_INT)    ? {4'h0, int_reg} :
    (ptr == REG_STATUS) ? {2'h0, fm_pd, pwr_ok, ovp_sbu, ovp_cc, SBU_SW_CLOSE_O, CC_SW_CLOSE_O} :
    8'h00;

  // Serial slave; the R/W bit of the address byte picks the direction.
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      state   <= ST_IDLE;
      bit_cnt <= 4'h0;
      shreg   <= 8'h00;
      ptr     <= 8'h00;
      first   <= 1'b0;
      ptr_ph  <= 1'b0;
      is_read <= 1'b0;
      hnack   <= 1'b0;
      sda_oe  <= 1'b0;
      wr_en   <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 8'h00;
      int_clr <= 1'b0;
      int_rd  <= 4'h0;
    end else begin
      wr_en   <= 1'b0;
      int_clr <= 1'b0;
      if (start_c) begin
        state   <= ST_RX;
        bit_cnt <= 4'h0;
        first   <= 1'b1;
        sda_oe  <= 1'b0;
      end else if (stop_c) begin
        state  <= ST_IDLE;
        sda_oe <= 1'b0;
      end else if (load_now) begin
        shreg   <= rd_data;
        sda_oe  <= ~rd_data[7];
        ptr     <= ptr + 8'h01;
        bit_cnt <= 4'h0;
        state   <= ST_TX;
        int_clr <= (ptr == REG_INT);
        int_rd  <= int_reg;
      end else begin
        case (state)
          ST_RX: begin
            if (scl_rise) begin
              shreg   <= {shreg[6:0], sda};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == 4'h8) begin
              bit_cnt <= 4'h0;
              first   <= 1'b0;
              if (first) begin
                is_read <= shreg[0];
                ptr_ph  <= ~shreg[0];
                sda_oe  <= addr_match;
                state   <= addr_match ? ST_ACK : ST_WAIT;
              end else begin
                sda_oe <= 1'b1;
                state  <= ST_ACK;
                ptr_ph <= 1'b0;
                if (ptr_ph) begin
                  ptr <= shreg;
                end else begin
                  wr_en   <= 1'b1;
                  wr_addr <= ptr;
                  wr_data <= shreg;
                  ptr     <= ptr + 8'h01;
                end
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              sda_oe <= 1'b0;
              state  <= ST_RX;
            end
          end
          ST_TX: begin
            if (scl_fall) begin
              shreg   <= {shreg[6:0], 1'b0};
              bit_cnt <= bit_cnt + 4'h1;
              sda_oe  <= (bit_cnt == 4'h7) ? 1'b0 : ~shreg[6];
              state   <= (bit_cnt == 4'h7) ? ST_HACK : ST_TX;
            end
          end
          ST_HACK: begin
            if (scl_rise) begin
              hnack <= sda;
            end else if (scl_fall) begin
              state <= ST_WAIT;
            end
          end
          ST_WAIT: begin
            sda_oe <= 1'b0;
          end
          default: begin
            state  <= ST_IDLE;
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  wire devrst_wr = wr_en & (wr_addr == REG_DEVRST) & wr_data[DEVRST_BIT];
  wire [3:0] raw_ev = {~ovp_sbu & ovp_sbu_d, ~ovp_cc & ovp_cc_d, ovp_sbu & ~ovp_sbu_d, ovp_cc & ~ovp_cc_d};
  wire [3:0] ev     = raw_ev & ~mask;
  wire [3:0] clr    = int_clr ? int_rd : 4'h0;
  // A bit that arrived after the read data was loaded was never seen, so it keeps the pin low.
  wire int_unread   = (int_reg & ~int_rd) != 4'h0;

  // The device reset bit self-clears and pulses every register back to default.
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      soft_rst <= 1'b0;
    end else begin
      soft_rst <= devrst_wr;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I || soft_rst) begin
      man_active <= CTRL_RST;
      man_cfg    <= SWCTL_RST;
      swctl      <= SWCTL_RST;
      mask       <= MASK_RST;
      int_reg    <= INT_RST;
    end else begin
      if (wr_en && wr_addr == REG_SWCTL) begin
        swctl <= wr_data[2:0];
      end
      // Settings take effect only when the apply bit is written, not on the settings write.
      if (wr_en && wr_addr == REG_CTRL) begin
        man_active <= wr_data[CTRL_MAN_BIT];
        man_cfg    <= swctl;
      end
      if (wr_en && wr_addr == REG_MASK) begin
        mask <= wr_data[3:0];
      end
      // Only bits that were actually read are cleared, and a new event wins.
      int_reg <= (int_reg & ~clr) | ev;
    end
  end

  // Live from reset with no setup; a read of the interrupt register releases it.
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      int_low <= 1'b0;
    end else if (ev != 4'h0) begin
      int_low <= 1'b1;
    end else if (int_clr && !int_unread) begin
      int_low <= 1'b0;
    end
  end

  // Hold switches open after any reset; the factory pin strap is sampled meanwhile.
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I || soft_rst) begin
      hold <= RST_HOLD_CYC;
    end else if (hold != 4'h0) begin
      hold <= hold - 4'h1;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      fm_pd <= 1'b1;
    end else if (hold != 4'h0) begin
      fm_pd <= fm_pin;
    end
  end

  wire auto_ok   = pwr_ok & (hold == 4'h0) & ~soft_rst;
  wire want_cc   = man_active ? man_cfg[SW_CC_BIT] : 1'b1;
  wire want_sbu  = man_active ? man_cfg[SW_SBU_BIT] : 1'b1;
  wire fm_sel2   = man_active & man_cfg[SW_FM_SBU2_BIT];
  wire next_cc   = auto_ok & ~ovp_cc & want_cc;
  wire sbu_ok    = auto_ok & ~ovp_sbu & want_sbu;
  wire next_sbu  = sbu_ok & fm_pd;
  wire next_fm1  = sbu_ok & ~fm_pd & ~fm_sel2;
  wire next_fm2  = sbu_ok & ~fm_pd & fm_sel2;
  wire next_rd   = ~pwr_ok;

  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      CC_SW_CLOSE_O     <= 1'b0;
      SBU_SW_CLOSE_O    <= 1'b0;
      DEAD_BATT_RD_O    <= 1'b1;
      FM_TO_SBU1_O      <= 1'b0;
      FM_TO_SBU2_O      <= 1'b0;
      SDA_O             <= 1'b0;
      INTERRUPT_OUT_N_O <= 1'b0;
    end else begin
      CC_SW_CLOSE_O     <= next_cc;
      SBU_SW_CLOSE_O    <= next_sbu;
      DEAD_BATT_RD_O    <= next_rd;
      FM_TO_SBU1_O      <= next_fm1;
      FM_TO_SBU2_O      <= next_fm2;
      SDA_O             <= 1'b0;
      INTERRUPT_OUT_N_O <= 1'b0;
    end
  end

  // Open-drain pins only ever pull low, so the enables carry the level.
  assign SDA_OE_O             = sda_oe;
  assign INTERRUPT_OUT_N_OE_O = int_low;

  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RST_N_I);

  sequence s_devrst_req;
    devrst_wr;
  endsequence

  sequence s_sw_open4;
    (!CC_SW_CLOSE_O && !SBU_SW_CLOSE_O)[*4];
  endsequence

  a_devrst_open: assert property (s_devrst_req |=> ##1 s_sw_open4)
    else $error("Switches not held open after device reset");
  a_ovp_cc_open: assert property (ovp_cc |=> !CC_SW_CLOSE_O)
    else $error("CC path not opened on over-voltage");
  a_ovp_split_path: assert property ((ovp_cc && !ovp_sbu && fm_pd && auto_ok && !man_active)
    |=> !CC_SW_CLOSE_O && SBU_SW_CLOSE_O)
    else $error("CC fault disturbed the SBU path");
  a_ovp_recover_path: assert property (($fell(ovp_cc) && auto_ok && !man_active)
    |=> CC_SW_CLOSE_O && (mask[INT_REC_CC] || int_reg[INT_REC_CC]))
    else $error("No reclose or recovery flag after fault removal");
  a_rd_no_supply: assert property (!pwr_ok |=> DEAD_BATT_RD_O && !CC_SW_CLOSE_O && !SBU_SW_CLOSE_O)
    else $error("Pulldown missing or switch closed without supply");
  a_auto_close: assert property ((auto_ok && !man_active && !ovp_cc && !ovp_sbu && fm_pd)
    |=> CC_SW_CLOSE_O && SBU_SW_CLOSE_O && !DEAD_BATT_RD_O)
    else $error("Switches not closed with valid supply");
  a_fm_route_sbu1: assert property ((auto_ok && !fm_pd && !ovp_sbu && !man_active)
    |=> FM_TO_SBU1_O && !FM_TO_SBU2_O && !SBU_SW_CLOSE_O)
    else $error("Factory pin not routed to SBU1");
  a_manual_open: assert property ((auto_ok && man_active && !man_cfg[SW_CC_BIT]) |=> !CC_SW_CLOSE_O)
    else $error("Manual open not honoured");
  a_int_assert: assert property ((ev != 4'h0) |=> INTERRUPT_OUT_N_OE_O ##1 INTERRUPT_OUT_N_OE_O)
    else $error("Interrupt output not asserted on event");
  a_int_held: assert property ((int_low && !int_clr) |=> int_low)
    else $error("Interrupt released without a read");
  a_int_release: assert property ((int_clr && ev == 4'h0 && !int_unread) |=> !INTERRUPT_OUT_N_OE_O)
    else $error("Interrupt not released by read");
  a_mask_block: assert property ((mask[INT_OVP_CC] && !int_reg[INT_OVP_CC] && !soft_rst)
    |=> !int_reg[INT_OVP_CC])
    else $error("Masked interrupt bit was set");

endmodule : csp_protect_ctrl

// File: sim/csp_i2c_host.sv
// Behavioural serial host that drives the control port and collects read data.
`timescale 1ns/100ps
module csp_i2c_host
  import csp_pkg::*;
(
  // Clock
  input  wire logic       clk_i,
  // Serial lines
  input  wire logic       sda_i,
  output logic            scl_o,
  output logic            sda_low_o,
  // Read results
  output logic            rd_stb_o,
  output logic [7:0]      rd_data_o
);
  int nacks;

  initial begin
    scl_o = 1'h1;
    sda_low_o = 1'h0;
    rd_stb_o = 1'h0;
    rd_data_o = 8'h00;
    nacks = 0;
  end

  // Steps land 2 ns after an edge, so no pin moves on the sampling edge.
  task automatic tk(input int n);
    repeat (n) @(posedge clk_i);
    #2;
  endtask : tk

  // A 66 cycle low phase keeps the low time legal; 126 cycles a bit stays under the clock limit.
  task automatic bt(input logic b, output logic r);
    tk(33);
    sda_low_o = ~b;
    tk(33);
    scl_o = 1'h1;
    tk(30);
    r = sda_i;
    tk(30);
    scl_o = 1'h0;
  endtask : bt

  task automatic sta();
    tk(33);
    sda_low_o = 1'h0;
    tk(33);
    scl_o = 1'h1;
    tk(33);
    sda_low_o = 1'h1;
    tk(33);
    scl_o = 1'h0;
  endtask : sta

  task automatic sto();
    tk(33);
    sda_low_o = 1'h1;
    tk(33);
    scl_o = 1'h1;
    tk(33);
    sda_low_o = 1'h0;
    tk(33);
  endtask : sto

  task automatic by(input logic [7:0] d, input logic a, output logic [7:0] r, output logic k);
    logic x;
    for (int i = 7; i >= 0; i--) begin
      bt(d[i], x);
      r[i] = x;
    end
    bt(a, k);
  endtask : by

  task automatic wr_reg(input logic [6:0] a, input logic [7:0] o, input logic [7:0] d);
    logic [7:0] r;
    logic       k;
    sta();
    by({a, 1'h0}, 1'h1, r, k);
    if (k) begin
      nacks++;
    end else begin
      by(o, 1'h1, r, k);
      by(d, 1'h1, r, k);
    end
    sto();
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] o);
    logic [7:0] r;
    logic       k;
    sta();
    by({I2C_ADDR, 1'h0}, 1'h1, r, k);
    by(o, 1'h1, r, k);
    sta();
    by({I2C_ADDR, 1'h1}, 1'h1, r, k);
    by(8'hFF, 1'h1, r, k);
    sto();
    rd_data_o = r;
    rd_stb_o = 1'h1;
    tk(1);
    rd_stb_o = 1'h0;
  endtask : rd_reg
endmodule : csp_i2c_host

// File: sim/cc_sbu_switch_protection_ctrl_tb_top.sv
// Self-checking bench of the protection switch controller.
`timescale 1ns/100ps
module cc_sbu_switch_protection_ctrl_tb_top;
  import csp_pkg::*;
  logic       clk, rst_n, vdd, ovp_cc, ovp_sbu, fm_pd;
  logic       scl, sda_low, sda_oe, sda_o, int_o, int_oe, rd_stb;
  logic       cc, sbu, db, fm1, fm2;
  logic [7:0] rd_data;
  logic [7:0] rnd;
  logic [7:0] exp_q[$];
  int         bad_count;
  int         n_checks;
  // Both lines are pulled up; a low wins over the pull-up.
  wire        sda = ~(sda_low | (sda_oe & ~sda_o));
  wire        int_n = ~(int_oe & ~int_o);
  wire [5:0]  outs = {int_n, fm2, fm1, db, sbu, cc};

  csp_protect_ctrl i_csp_protect_ctrl (
    .CLOCK_I(clk), .RST_N_I(rst_n), .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE_O(sda_oe),
    .INTERRUPT_OUT_N_O(int_o), .INTERRUPT_OUT_N_OE_O(int_oe), .VDD_VALID_I(vdd),
    .OVP_CC_I(ovp_cc), .OVP_SBU_I(ovp_sbu), .FACTORY_TEST_PIN_PD_I(fm_pd), .CC_SW_CLOSE_O(cc),
    .SBU_SW_CLOSE_O(sbu), .DEAD_BATT_RD_O(db), .FM_TO_SBU1_O(fm1), .FM_TO_SBU2_O(fm2));

  csp_i2c_host i_csp_i2c_host (
    .clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low), .rd_stb_o(rd_stb),
    .rd_data_o(rd_data));

  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end

  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : lfsr

  task automatic tk(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : tk

  task automatic fail(input string m);
    bad_count++;
    $display("[ERR] %0t %s", $time, m);
  endtask : fail

  task automatic test_done();
    if (exp_q.size() != 0) fail("read never answered");
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : test_done

  // Waits at most n cycles for the level, then compares.
  task automatic chk_pin(input int s, input logic e, input int n);
    int i;
    i = 0;
    while (outs[s] !== e && i < n) begin
      tk(1);
      i++;
    end
    n_checks++;
    if (outs[s] !== e) fail("pin level wrong");
  endtask : chk_pin

  task automatic cmp_reg(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) fail("read data wrong");
  endtask : cmp_reg

  task automatic rd(input logic [7:0] o, input logic [7:0] e);
    exp_q.push_back(e);
    i_csp_i2c_host.rd_reg(o);
  endtask : rd

  task automatic wr(input logic [7:0] o, input logic [7:0] d);
    i_csp_i2c_host.wr_reg(I2C_ADDR, o, d);
  endtask : wr

  always @(posedge clk) begin
    if (rd_stb === 1'h1) begin
      if (exp_q.size() == 0) fail("unexpected read");
      else cmp_reg(rd_data, exp_q.pop_front());
    end
  end

  initial begin
    repeat (100000) @(posedge clk);
    fail("run timed out");
    test_done();
  end

  initial begin
    rst_n = 1'h0;
    vdd = 1'h0;
    ovp_cc = 1'h0;
    ovp_sbu = 1'h0;
    fm_pd = 1'h1;
    bad_count = 0;
    n_checks = 0;
    rnd = 8'h52;
    tk(6);
    rst_n = 1'h1;
    tk(30);
    chk_pin(2, 1'h1, 0);
    chk_pin(0, 1'h0, 0);
    $display("test dead battery done");
    vdd = 1'h1;
    chk_pin(0, 1'h1, 40);
    chk_pin(1, 1'h1, 40);
    chk_pin(2, 1'h0, 40);
    rd(REG_MASK, 8'h00);
    rd(REG_STATUS, 8'h33);
    rd(8'h01, 8'h00);
    i_csp_i2c_host.wr_reg(7'h29, REG_MASK, 8'h0F);
    cmp_reg(8'(i_csp_i2c_host.nacks), 8'h01);
    $display("test power up done");
    // A two-cycle spike must not reach the switch or the interrupt.
    ovp_cc = 1'h1;
    tk(2);
    ovp_cc = 1'h0;
    repeat (12) begin
      tk(1);
      chk_pin(0, 1'h1, 0);
    end
    chk_pin(5, 1'h1, 0);
    ovp_cc = 1'h1;
    chk_pin(0, 1'h0, 25);
    chk_pin(1, 1'h1, 0);
    chk_pin(5, 1'h0, 25);
    ovp_cc = 1'h0;
    chk_pin(0, 1'h1, 25);
    chk_pin(5, 1'h0, 0);
    rd(REG_INT, 8'h05);
    chk_pin(5, 1'h1, 3);
    ovp_sbu = 1'h1;
    chk_pin(1, 1'h0, 25);
    chk_pin(0, 1'h1, 0);
    chk_pin(5, 1'h0, 25);
    ovp_sbu = 1'h0;
    chk_pin(1, 1'h1, 25);
    rd(REG_INT, 8'h0A);
    chk_pin(5, 1'h1, 3);
    $display("test over-voltage done");
    wr(REG_MASK, 8'h0F);
    ovp_cc = 1'h1;
    chk_pin(0, 1'h0, 25);
    ovp_cc = 1'h0;
    chk_pin(0, 1'h1, 25);
    tk(20);
    chk_pin(5, 1'h1, 0);
    rd(REG_INT, 8'h00);
    rnd = lfsr(rnd);
    wr(REG_MASK, {4'h0, rnd[3:0]});
    rd(REG_MASK, {4'h0, rnd[3:0]});
    $display("test masking done");
    wr(REG_SWCTL, 8'h02);
    chk_pin(0, 1'h1, 0);
    wr(REG_CTRL, 8'h01);
    chk_pin(0, 1'h0, 40);
    chk_pin(1, 1'h1, 0);
    ovp_sbu = 1'h1;
    chk_pin(1, 1'h0, 25);
    ovp_sbu = 1'h0;
    chk_pin(1, 1'h1, 25);
    $display("test manual done");
    fork
      wr(REG_DEVRST, 8'h01);
      begin
        chk_pin(1, 1'h0, 4000);
        chk_pin(1, 1'h1, 20);
      end
    join
    chk_pin(0, 1'h1, 40);
    rd(REG_SWCTL, 8'h03);
    rd(REG_MASK, 8'h00);
    $display("test device reset done");
    fm_pd = 1'h0;
    wr(REG_DEVRST, 8'h01);
    chk_pin(3, 1'h1, 40);
    chk_pin(4, 1'h0, 0);
    chk_pin(1, 1'h0, 0);
    wr(REG_SWCTL, 8'h07);
    wr(REG_CTRL, 8'h01);
    chk_pin(4, 1'h1, 40);
    chk_pin(3, 1'h0, 0);
    $display("test factory pin done");
    vdd = 1'h0;
    chk_pin(0, 1'h0, 25);
    chk_pin(2, 1'h1, 25);
    cmp_reg(8'(i_csp_i2c_host.nacks), 8'h01);
    $display("test undervoltage done");
    test_done();
  end
endmodule : cc_sbu_switch_protection_ctrl_tb_top
